// >>> logic/ram_alarm.sv
// Purpose: alarm unit of a real time clock with interrupt output
// Assumes: time bytes come from the clock registers, sec_tick marks each update
// Notes:   byte register port; status at 07h, control at 08h
`timescale 1ns/1ps
module ram_alarm (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // current time: seconds, minutes, hours, date, month, weekday
  input  wire logic [7:0] time_sec,
  input  wire logic [7:0] time_min,
  input  wire logic [7:0] time_hour,
  input  wire logic [7:0] time_date,
  input  wire logic [7:0] time_month,
  input  wire logic [7:0] time_wday,
  input  wire logic       sec_tick,
  // interrupt pin
  output logic            irq_n
);
  typedef struct packed {
    logic [5:0][7:0] alarm;
    logic            alarm_flag;
    logic            read_auto_clear;
    logic            repeat_select;
    logic            frequency_output;
    logic            tick_d;
    logic [7:0]      rdata;
  } ram_alarm_s;
  ram_alarm_s r;
  ram_alarm_s next_r;
  ram_cmp_if  cmp ();
  logic       pulse_trig;
  logic       pulse_active;
  logic       mode_ok;
  logic       fire;
  logic       sel_alarm;
  // feed comparator
  genvar i;
  generate
    for (i = 0; i < ram_pkg::NUM_ALARM; i++) begin : g_a
      assign cmp.alarm_byte[i] = r.alarm[i];
    end
  endgenerate
  assign cmp.time_byte[0] = time_sec;
  assign cmp.time_byte[1] = time_min;
  assign cmp.time_byte[2] = time_hour;
  assign cmp.time_byte[3] = time_date;
  assign cmp.time_byte[4] = time_month;
  assign cmp.time_byte[5] = time_wday;
  ram_compare u_cmp (
    .c (cmp)
  );
  // evaluate one cycle after the time update so the new time is settled
  // minute-level matches hit only on the 59->00 roll since fields change then
  assign mode_ok = cmp.any_enable && !r.frequency_output;
  assign fire    = r.tick_d && mode_ok && cmp.match && !(
                   !r.repeat_select && r.alarm_flag) && (r.alarm[0][ram_pkg::ENABLE_BIT] ||
                   time_sec[6:0] == 7'h00);
  assign pulse_trig = fire && r.repeat_select;
  ram_pulse u_pulse (
    .ref_clk (ref_clk),
    .rst     (rst),
    .trig    (pulse_trig),
    .active  (pulse_active)
  );
  assign sel_alarm = (reg_addr >= ram_pkg::ADDR_ALARM_FIRST) && (reg_addr <= ram_pkg::ADDR_ALARM_LAST);
  // next state: register writes, read side effects, flag update
  always_comb begin
    next_r        = r;
    next_r.tick_d = sec_tick;
    if (reg_wr) begin
      if (sel_alarm) begin
        next_r.alarm[reg_addr[2:0]] = reg_wdata;
      end else if (reg_addr == ram_pkg::ADDR_STATUS) begin
        if (!reg_wdata[ram_pkg::FLAG_BIT]) begin
          next_r.alarm_flag = 1'b0;
        end
      end else if (reg_addr == ram_pkg::ADDR_CONTROL) begin
        next_r.read_auto_clear  = reg_wdata[ram_pkg::AUTO_CLEAR_BIT];
        next_r.repeat_select    = reg_wdata[ram_pkg::REPEAT_BIT];
        next_r.frequency_output = reg_wdata[ram_pkg::FREQ_OUT_BIT];
      end
    end
    if (reg_rd) begin
      if (sel_alarm) begin
        next_r.rdata = r.alarm[reg_addr[2:0]];
      end else if (reg_addr == ram_pkg::ADDR_STATUS) begin
        next_r.rdata = {1'b0, r.alarm_flag, 6'h00};
        if (r.read_auto_clear) begin
          next_r.alarm_flag = 1'b0;
        end
      end else if (reg_addr == ram_pkg::ADDR_CONTROL) begin
        next_r.rdata = {r.read_auto_clear, r.repeat_select, 5'h00, r.frequency_output};
      end else begin
        next_r.rdata = 8'h00;
      end
    end
    // set wins over any clear in the same cycle
    if (fire) begin
      next_r.alarm_flag = 1'b1;
    end
  end
  // state register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign reg_rdata = r.rdata;
  // level in single event mode, pulse in repeat mode
  assign irq_n = r.repeat_select ? !pulse_active : !(r.alarm_flag && !r.frequency_output);

  a_level_hold: assert property (@(posedge ref_clk) disable iff (rst)
    (!r.repeat_select && r.alarm_flag && !r.frequency_output) |-> !irq_n)
    else $error("irq not low while single alarm flag set");
  a_fire_sets: assert property (@(posedge ref_clk) disable iff (rst)
    fire |=> r.alarm_flag)
    else $error("match did not set alarm flag");
  a_auto_clear: assert property (@(posedge ref_clk) disable iff (rst)
    (reg_rd && reg_addr == ram_pkg::ADDR_STATUS && r.read_auto_clear && !fire) |=> !r.alarm_flag)
    else $error("auto clear on read failed");
  a_write_clear: assert property (@(posedge ref_clk) disable iff (rst)
    (reg_wr && reg_addr == ram_pkg::ADDR_STATUS && !reg_wdata[ram_pkg::FLAG_BIT] && !fire) |=> !r.alarm_flag)
    else $error("write zero did not clear flag");
  a_pulse_low: assert property (@(posedge ref_clk) disable iff (rst)
    (pulse_trig && r.repeat_select) |=> !irq_n)
    else $error("repeat match gave no pulse");
  a_pulse_ends: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(pulse_active) |-> $past(!pulse_trig))
    else $error("pulse ended at retrigger");
  a_no_enable: assert property (@(posedge ref_clk) disable iff (rst)
    !cmp.any_enable |-> !fire)
    else $error("alarm fired with no byte enabled");
  a_single_once: assert property (@(posedge ref_clk) disable iff (rst)
    (r.alarm_flag && !r.repeat_select) |-> !fire)
    else $error("second single event while flag set");
  a_min_roll: assert property (@(posedge ref_clk) disable iff (rst)
    (fire && !r.alarm[0][ram_pkg::ENABLE_BIT]) |-> time_sec[6:0] == 7'h00)
    else $error("minute match off the seconds roll");
endmodule

// >>> logic/ram_cmp_if.sv
// Purpose: carries alarm bytes and time to the comparator
// Assumes: one clock domain
// Notes:   purely combinational bundle
`timescale 1ns/1ps
interface ram_cmp_if;
  logic [7:0] alarm_byte [6];
  logic [7:0] time_byte  [6];
  logic       match;
  logic       any_enable;
  modport top (output alarm_byte, output time_byte, input match, input any_enable);
  modport cmp (input alarm_byte, input time_byte, output match, output any_enable);
endinterface

// >>> logic/ram_compare.sv
// Purpose: field-by-field equality of enabled alarm bytes
// Assumes: alarm and time bytes share one coding
// Notes:   no enabled byte means no match
`timescale 1ns/1ps
module ram_compare (
  // comparison bundle
  ram_cmp_if.cmp c
);
  logic [5:0] field_ok;
  logic [5:0] field_en;
  // per-byte compare; disabled bytes always agree
  genvar i;
  generate
    for (i = 0; i < ram_pkg::NUM_ALARM; i++) begin : g_f
      assign field_en[i] = c.alarm_byte[i][ram_pkg::ENABLE_BIT];
      assign field_ok[i] = !field_en[i] || (c.alarm_byte[i][6:0] == c.time_byte[i][6:0]);
    end
  endgenerate
  assign c.any_enable = |field_en;
  assign c.match      = c.any_enable && (&field_ok);
endmodule

// >>> logic/ram_pkg.sv
// Purpose: shared constants and types for the alarm match unit
// Assumes: byte-wide register port, 40 MHz ref_clk
// Notes:   offsets are byte addresses of the device register map
package ram_pkg;
  localparam logic [7:0] ADDR_ALARM_FIRST = 8'h10;
  localparam logic [7:0] ADDR_ALARM_LAST  = 8'h15;
  localparam logic [7:0] ADDR_STATUS      = 8'h07;
  localparam logic [7:0] ADDR_CONTROL     = 8'h08;
  localparam int         NUM_ALARM        = 6;
  localparam int         ENABLE_BIT       = 7;
  localparam int         FLAG_BIT         = 6;
  localparam int         AUTO_CLEAR_BIT   = 7;
  localparam int         REPEAT_BIT       = 6;
  localparam int         FREQ_OUT_BIT     = 0;
  localparam logic [7:0] ALARM_RESET      = 8'h00;
  localparam logic [7:0] CONTROL_RESET    = 8'h00;
  localparam int         CLK_HZ           = 40000000;
  localparam int         PULSE_NS         = 250000;
  localparam int         PULSE_CYCLES     = PULSE_NS / (1000000000 / CLK_HZ);
  localparam int         PW               = 14;
  typedef enum logic [1:0] {RAM_IDLE, RAM_PULSE} ram_state_e;
endpackage

// >>> logic/ram_pulse.sv
// Purpose: fixed-width pulse stretcher for pulsed interrupt mode
// Assumes: trigger is a one-cycle strobe
// Notes:   retrigger during a pulse restarts the width
`timescale 1ns/1ps
module ram_pulse (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // trigger and output
  input  wire logic trig,
  output logic      active
);
  typedef struct packed {
    ram_pkg::ram_state_e st;
    logic [ram_pkg::PW-1:0] cnt;
  } ram_pulse_s;
  ram_pulse_s r;
  ram_pulse_s next_r;
  // count the pulse width down
  always_comb begin
    next_r = r;
    if (trig) begin
      next_r.st  = ram_pkg::RAM_PULSE;
      next_r.cnt = ram_pkg::PW'(ram_pkg::PULSE_CYCLES - 1);
    end else begin
      case (r.st)
        ram_pkg::RAM_PULSE: begin
          if (r.cnt == '0) begin
            next_r.st = ram_pkg::RAM_IDLE;
          end else begin
            next_r.cnt = r.cnt - 1'b1;
          end
        end
        default: next_r.st = ram_pkg::RAM_IDLE;
      endcase
    end
  end
  // register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r <= '{ram_pkg::RAM_IDLE, '0};
    end else begin
      r <= next_r;
    end
  end
  assign active = (r.st == ram_pkg::RAM_PULSE);
endmodule

// >>> sim/ram_alarm_tb.sv
// Purpose: self-checking bench for the alarm unit
// Assumes: inputs move at the falling edge
// Notes:   pulse width is fixed, so repeat checks take 10000 cycles each
`timescale 1ns/1ps
module ram_alarm_tb;
  logic        ref_clk, rst, reg_wr, reg_rd, sec_tick, irq_n;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, rv;
  logic [7:0]  tm [6];
  logic [7:0]  al [6];
  logic [31:0] seed;
  int          num_errors, n_compared, j;
  ram_alarm i_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .time_sec(tm[0]), .time_min(tm[1]),
    .time_hour(tm[2]), .time_date(tm[3]), .time_month(tm[4]), .time_wday(tm[5]),
    .sec_tick(sec_tick), .irq_n(irq_n));
  ram_host i_host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // expected fire: all enabled fields equal, seconds roll when seconds unused
  function automatic logic exp_fire();
    logic hit, any;
    hit = al[0][7] | (tm[0] == 8'h00);
    any = 1'b0;
    for (int i = 0; i < 6; i++) begin
      any = any | al[i][7];
      if (al[i][7] && (al[i][6:0] != tm[i][6:0])) hit = 1'b0;
    end
    return hit & any;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ck_irq(input logic e);
    chk({7'h00, irq_n}, {7'h00, e});
  endtask
  // one time update, then two cycles for the flag to land
  task automatic tick();
    @(negedge ref_clk);
    sec_tick = 1'b1;
    @(negedge ref_clk);
    sec_tick = 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask
  task automatic prog(input logic [47:0] v, input logic [47:0] t);
    for (int i = 0; i < 6; i++) begin
      {al[i], tm[i]} = {v[47-8*i -: 8], t[47-8*i -: 8]};
      i_host.wr(8'h10 + 8'(i), al[i]);
    end
  endtask
  task automatic close_out();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // watchdog well past the expected 20000 cycles
  initial begin
    #2000000;
    num_errors++;
    close_out();
  end
  initial begin
    {rst, sec_tick, num_errors, n_compared, seed} = {2'b10, 64'h0, 32'd32355};
    for (int i = 0; i < 6; i++) {tm[i], al[i]} = 16'h0;
    repeat (16) @(negedge ref_clk);
    rst = 1'b0;
    // reset values, unmapped 16h reads zero
    for (int i = 0; i < 7; i++) begin
      i_host.rd(8'h10 + 8'(i), rv);
      chk(rv, 8'h00);
    end
    ck_irq(1'b1);
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      i_host.wr(8'h10 + 8'(i), seed[7:0]);
      i_host.rd(8'h10 + 8'(i), rv);
      chk(rv, seed[7:0]);
    end
    // random enable sets, first pass with none enabled
    for (int k = 0; k < 8; k++) begin
      for (int i = 0; i < 6; i++) begin
        seed  = xs(seed);
        al[i] = {(k != 0) & seed[9], seed[6:0]};
        tm[i] = {1'b0, seed[6:0]};
        i_host.wr(8'h10 + 8'(i), al[i]);
      end
      if (!al[0][7]) tm[0] = 8'h00;
      for (j = 5; j >= 0; j--) if (al[j][7]) break;
      if (j >= 0) tm[j] = tm[j] ^ 8'h01;
      tick();
      ck_irq(!exp_fire());
      if (j >= 0) tm[j] = tm[j] ^ 8'h01;
      tick();
      ck_irq(!exp_fire());
      i_host.wr(8'h07, 8'h00);
    end
    // minute alarm without seconds, 11:30 on the first of January
    prog(48'h00b091818100, 48'h593011010103);
    tick();
    ck_irq(1'b1);
    tm[0] = 8'h00;
    tick();
    ck_irq(1'b0);
    tick();
    ck_irq(1'b0);
    i_host.wr(8'h07, 8'h00);
    ck_irq(1'b1);
    i_host.wr(8'h08, 8'h80);
    i_host.rd(8'h08, rv);
    chk(rv, 8'h80);
    tick();
    i_host.rd(8'h07, rv);
    chk(rv, 8'h40);
    i_host.rd(8'h07, rv);
    chk(rv, 8'h00);
    ck_irq(1'b1);
    // frequency output on blocks the alarm
    i_host.wr(8'h08, 8'h01);
    tick();
    ck_irq(1'b1);
    // repeat mode on seconds 30, flag never serviced between pulses
    i_host.wr(8'h08, 8'h40);
    prog(48'hb00000000000, 48'h300000000000);
    for (int p = 0; p < 2; p++) begin
      tick();
      ck_irq(1'b0);
      repeat (9990) @(negedge ref_clk);
      ck_irq(1'b0);
      repeat (20) @(negedge ref_clk);
      ck_irq(1'b1);
    end
    i_host.wr(8'h07, 8'h00);
    tick();
    i_host.rd(8'h07, rv);
    chk(rv, 8'h40);
    close_out();
  end
endmodule

// >>> sim/ram_host.sv
// Purpose: host model on the register port
// Assumes: strobes move at the falling edge
// Notes:   read data taken one cycle after strobe
`timescale 1ns/1ps
module ram_host (
  // clock
  input  wire logic       ref_clk,
  // register port
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  // idle until the first request
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h0;
  end
  // one write; status 8'h00 clears the flag
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(negedge ref_clk);
    reg_wr    = 1'b0;
    reg_wdata = ~d; // stale data scrambled once released
  endtask
  // one read, data registered a cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    {reg_addr, reg_rd} = {a, 1'b1};
    @(negedge ref_clk);
    reg_rd = 1'b0;
    d      = reg_rdata;
  endtask
endmodule
